// ===== hw/dual_slope_phase_sequencer.sv
/*
 * Phase sequencer and reading counter for a dual-slope converter.
 * Assumes the analog front end returns an asynchronous comparator
 * zero-crossing level and a polarity level.
 * Outputs are registered; the four phase levels are one-hot, and all low while rst is held.
 * rst is synchronous and may be raised at any point of a cycle.
 */
`timescale 1ns/10ps
module dual_slope_phase_sequencer import phase_seq_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic zeroCross,
  input wire logic polarityIn,
  output logic autoZeroEn,
  output logic integrateEn,
  output logic deintEn,
  output logic dischargeEn,
  output logic refNegSel,
  output logic signNeg,
  output logic [CNT_W-1:0] reading,
  output logic overrange,
  output logic readingValid,
  output logic countTick
);
  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic zcMeta_r, zcSync_r, polMeta_r, polSync_r;
  always_ff @(posedge clk) begin
    zcMeta_r <= zeroCross;
    zcSync_r <= zcMeta_r;
    polMeta_r <= polarityIn;
    polSync_r <= polMeta_r;
  end

  // ---------------------------------------------
  // prescaler
  // ---------------------------------------------
  logic [1:0] pre_r;
  wire tick = (pre_r == PRESCALE_LAST);
  always_ff @(posedge clk) begin
    if (rst) pre_r <= '0;
    else pre_r <= pre_r + 2'h1;
  end

  // ---------------------------------------------
  // phase machine
  // ---------------------------------------------
  phase_e phase_r, phase_nxt;
  logic [CNT_W-1:0] cnt_r, cycle_r, azLen_r, dischLen_r, deintCnt_r;
  logic heavy_r;
  wire [CNT_W-1:0] cntNext = cnt_r + 12'h1;
  // ticks since integrate began, for the cycle check
  wire [CNT_W-1:0] cycNext = cycle_r + 12'h1;
  wire intStart = (phase_r == PH_AUTOZERO) && (phase_nxt == PH_INTEGRATE);
  wire azEnd = (cntNext == azLen_r);
  wire intEnd = (cntNext == INT_COUNTS);
  wire limitHit = (cntNext == FULL_SCALE);
  wire deintEnd = zcSync_r || limitHit;
  wire dischEnd = (cntNext == dischLen_r);
  // auto-zero takes what is left so the cycle stays fixed
  wire [CNT_W-1:0] azFill = CYCLE_COUNTS - INT_COUNTS - deintCnt_r - dischLen_r;

  always_comb begin
    phase_nxt = phase_r;
    // phases move only on a count tick
    if (tick) begin
      case (phase_r)
        PH_AUTOZERO: if (azEnd) phase_nxt = PH_INTEGRATE;
        PH_INTEGRATE: if (intEnd) phase_nxt = PH_DEINT;
        PH_DEINT: if (deintEnd) phase_nxt = PH_DISCHARGE;
        PH_DISCHARGE: if (dischEnd) phase_nxt = PH_AUTOZERO;
        default: phase_nxt = PH_AUTOZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= PH_AUTOZERO;
      cnt_r <= '0;
      cycle_r <= '0;
      azLen_r <= CYCLE_COUNTS - INT_COUNTS - FULL_SCALE - DISCH_NORMAL + 12'h1;
      dischLen_r <= DISCH_NORMAL;
      deintCnt_r <= '0;
      heavy_r <= 1'b0;
      refNegSel <= 1'b0;
      signNeg <= 1'b0;
      reading <= '0;
      overrange <= 1'b0;
      readingValid <= 1'b0;
    end else begin
      readingValid <= 1'b0;
      if (tick) begin
        phase_r <= phase_nxt;
        cycle_r <= intStart ? '0 : cycNext;
        cnt_r <= (phase_nxt != phase_r) ? '0 : cntNext;
        if (phase_r == PH_INTEGRATE && intEnd) begin
          refNegSel <= polSync_r;
          signNeg <= polSync_r;
        end
        if (phase_r == PH_DEINT && deintEnd) begin
          // elapsed counts, one more than the reading at a crossing
          deintCnt_r <= cntNext;
          reading <= zcSync_r ? cnt_r : cntNext;
          overrange <= !zcSync_r;
          heavy_r <= !zcSync_r;
          dischLen_r <= zcSync_r ? DISCH_NORMAL : DISCH_HEAVY;
          readingValid <= 1'b1;
        end
        if (phase_r == PH_DISCHARGE && dischEnd)
          azLen_r <= (azFill < AZ_MIN) ? AZ_MIN : azFill;
      end
    end
  end

  // ---------------------------------------------
  // phase outputs
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      autoZeroEn <= 1'b0;
      integrateEn <= 1'b0;
      deintEn <= 1'b0;
      dischargeEn <= 1'b0;
      countTick <= 1'b0;
    end else begin
      autoZeroEn <= (phase_nxt == PH_AUTOZERO);
      integrateEn <= (phase_nxt == PH_INTEGRATE);
      deintEn <= (phase_nxt == PH_DEINT);
      dischargeEn <= (phase_nxt == PH_DISCHARGE);
      countTick <= tick;
    end
  end

  // ---------------------------------------------
  // assertions: count rate and phase order
  // ---------------------------------------------
  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (rst) tick |=> !tick [*3])
    else $error("prescale tick spacing wrong");
  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    !tick |=> $stable(phase_r) && $stable(cnt_r))
    else $error("phase or count moved between ticks");
  AST_ONEHOT: assert property (@(posedge clk) disable iff (rst)
    $onehot(phase_r))
    else $error("phase state not one-hot");
  AST_PHASE_OUT: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> {dischargeEn, deintEn, integrateEn, autoZeroEn} == phase_r)
    else $error("phase levels disagree with phase state");
  AST_ORDER_INT: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_AUTOZERO && azEnd) |=> phase_r == PH_INTEGRATE)
    else $error("integrate must follow auto-zero");
  AST_ORDER_DEINT: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_INTEGRATE && intEnd) |=> phase_r == PH_DEINT)
    else $error("de-integrate must follow integrate");
  AST_ORDER_DISCH: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_DEINT && deintEnd) |=> phase_r == PH_DISCHARGE)
    else $error("discharge must follow de-integrate");
  AST_ORDER_AZ: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_DISCHARGE && dischEnd) |=> phase_r == PH_AUTOZERO)
    else $error("auto-zero must follow discharge");

  // ---------------------------------------------
  // assertions: phase lengths and reading
  // ---------------------------------------------
  AST_INT_LEN: assert property (@(posedge clk) disable iff (rst)
    (phase_r == PH_INTEGRATE && tick) |-> cnt_r < INT_COUNTS)
    else $error("integrate too long");
  AST_DEINT_LIMIT: assert property (@(posedge clk) disable iff (rst)
    phase_r == PH_DEINT |-> cnt_r < FULL_SCALE)
    else $error("de-integrate past limit");
  AST_ZC_END: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_DEINT && zcSync_r) |=> readingValid && !overrange && reading == $past(cnt_r))
    else $error("crossing did not end de-integrate with its count");
  AST_LIMIT_END: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_DEINT && limitHit && !zcSync_r) |=> overrange && reading == FULL_SCALE && dischLen_r == DISCH_HEAVY)
    else $error("limit did not flag overrange");
  AST_VALID_SRC: assert property (@(posedge clk) disable iff (rst)
    readingValid |-> $past(phase_r) == PH_DEINT && phase_r == PH_DISCHARGE)
    else $error("reading strobe outside de-integrate end");
  AST_VALID_PULSE: assert property (@(posedge clk) disable iff (rst)
    readingValid |=> !readingValid)
    else $error("reading strobe longer than one clock");
  AST_READING_MAX: assert property (@(posedge clk) disable iff (rst)
    readingValid |-> reading <= FULL_SCALE)
    else $error("reading above full scale");
  AST_OVR_HEAVY: assert property (@(posedge clk) disable iff (rst)
    overrange |-> dischLen_r == DISCH_HEAVY)
    else $error("overrange without heavy discharge");

  // ---------------------------------------------
  // assertions: discharge, auto-zero and cycle
  // ---------------------------------------------
  AST_DISCH_NORMAL: assert property (@(posedge clk) disable iff (rst)
    !heavy_r |-> dischLen_r == DISCH_NORMAL)
    else $error("discharge length wrong");
  AST_DISCH_RANGE: assert property (@(posedge clk) disable iff (rst)
    dischLen_r >= DISCH_MIN && dischLen_r <= DISCH_HEAVY)
    else $error("discharge length out of range");
  AST_AZ_MIN: assert property (@(posedge clk) disable iff (rst)
    azLen_r >= AZ_MIN)
    else $error("auto-zero too short");
  AST_AZ_RANGE: assert property (@(posedge clk) disable iff (rst)
    azLen_r <= CYCLE_COUNTS - INT_COUNTS - DISCH_MIN)
    else $error("auto-zero too long");
  AST_CYCLE: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_DISCHARGE && dischEnd) |=> azLen_r + cycle_r == CYCLE_COUNTS)
    else $error("cycle length not constant");

  // ---------------------------------------------
  // assertions: polarity
  // ---------------------------------------------
  AST_SIGN: assert property (@(posedge clk) disable iff (rst)
    (tick && phase_r == PH_INTEGRATE && intEnd) |=> signNeg == $past(polSync_r) && refNegSel == $past(polSync_r))
    else $error("polarity not latched at end of integrate");
  AST_POL_HOLD: assert property (@(posedge clk) disable iff (rst)
    !(tick && phase_r == PH_INTEGRATE && intEnd) |=> $stable(signNeg) && $stable(refNegSel))
    else $error("polarity changed outside end of integrate");

  // ---------------------------------------------
  // covers
  // ---------------------------------------------
  CV_OVERRANGE: cover property (@(posedge clk) disable iff (rst) readingValid && overrange);
  CV_NORMAL: cover property (@(posedge clk) disable iff (rst) readingValid && !overrange);
  CV_NEG: cover property (@(posedge clk) disable iff (rst) readingValid && signNeg);
  CV_ZERO_READING: cover property (@(posedge clk) disable iff (rst) readingValid && reading == '0);
  CV_HEAVY_CYCLE: cover property (@(posedge clk) disable iff (rst) tick && phase_r == PH_DISCHARGE && dischEnd && heavy_r);
endmodule // dual_slope_phase_sequencer

// ===== hw/phase_seq_pkg.sv
/*
 * Constants for the dual-slope converter phase sequencer.
 * Assumes one oscillator clock; all counts are prescaled by four.
 */
// Functional notes
// - counters advance once every four oscillator clocks
// - signal integrate lasts exactly 1000 counts
// - de-integrate runs 1 to 2000 counts, ends on zero crossing; reading is count less one at a crossing, 2000 at the limit
// - auto-zero lasts 260 to 2859 counts, varying per cycle
// - integrator discharge lasts 140 or 740 counts, varying per cycle
// - unused de-integrate counts are added to the next auto-zero
// - every full cycle is 4000 counts, 16000 oscillator clocks
// - full-scale reading is 2000 counts
// - phase order: auto-zero, integrate, de-integrate, discharge
// - polarity latched at end of integrate; selects reference and drives sign
// - discharge normally 140 counts, 740 after heavy overrange
package phase_seq_pkg;
  localparam int PRESCALE = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE - 1);
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CYCLE_COUNTS = 12'd4000;
  localparam logic [CNT_W-1:0] INT_COUNTS = 12'd1000;
  localparam logic [CNT_W-1:0] FULL_SCALE = 12'd2000;
  localparam logic [CNT_W-1:0] AZ_MIN = 12'd260;
  localparam logic [CNT_W-1:0] DISCH_NORMAL = 12'd140;
  localparam logic [CNT_W-1:0] DISCH_HEAVY = 12'd740;
  localparam logic [CNT_W-1:0] DISCH_MIN = 12'd11;
  typedef enum logic [3:0] {
    PH_AUTOZERO = 4'b0001,
    PH_INTEGRATE = 4'b0010,
    PH_DEINT = 4'b0100,
    PH_DISCHARGE = 4'b1000
  } phase_e;
endpackage

// ===== testbench/front_end_model.sv
/* analog front end: integrator with zero-crossing comparator.
   assumes one-hot phase levels and the sequencer's count tick. */
`timescale 1ns/10ps
module front_end_model (
  input wire logic clk,
  input wire logic integrateEn,
  input wire logic deintEn,
  input wire logic countTick,
  input wire logic [11:0] crossAt,
  output logic zeroCross
);
  int deintCount = 0;
  initial zeroCross = 1'b1;
  // off zero while integrating, back at zero after crossAt de-integrate counts
  always @(posedge clk) begin
    deintCount <= deintEn ? deintCount + int'(countTick) : 0;
    zeroCross <= #1 !(integrateEn || (deintEn && deintCount < int'(crossAt)));
  end
endmodule // front_end_model

// ===== testbench/test_dual_slope_phase_sequencer.sv
/* self-checking bench for the phase sequencer.
   assumes the package constants and the front end model. */
`timescale 1ns/10ps
module test_dual_slope_phase_sequencer;
  import phase_seq_pkg::*;
  logic clk = 0, rst, zeroCross, polarityIn = 0, autoZeroEn, integrateEn, deintEn, dischargeEn;
  logic refNegSel, signNeg, overrange, readingValid, countTick;
  logic [CNT_W-1:0] reading;
  logic [11:0] crossAt = 12'h000;
  int bad_count = 0, tests_run = 0, skipLen;
  wire [3:0] phases = {dischargeEn, deintEn, integrateEn, autoZeroEn};
  always #5 clk = ~clk;
  dual_slope_phase_sequencer dut (.clk(clk), .rst(rst), .zeroCross(zeroCross), .polarityIn(polarityIn),
    .autoZeroEn(autoZeroEn), .integrateEn(integrateEn), .deintEn(deintEn), .dischargeEn(dischargeEn),
    .refNegSel(refNegSel), .signNeg(signNeg), .reading(reading), .overrange(overrange),
    .readingValid(readingValid), .countTick(countTick));
  front_end_model fe (.clk(clk), .integrateEn(integrateEn), .deintEn(deintEn), .countTick(countTick),
    .crossAt(crossAt), .zeroCross(zeroCross));
  task results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] expv, input logic [31:0] got);
    tests_run++;
    if (got !== expv) begin
      $display("wrong value %s expected %0d seen %0d", what, expv, got);
      bad_count++;
    end
  endtask
  // --------------------------------------------------
  // clocks spent in one phase, waiting first for it
  // --------------------------------------------------
  task phase_len(input int ph, output int len);
    int n;
    n = 0;
    len = 0;
    while (phases[ph] !== 1'b1 && n < 20000) begin
      @(posedge clk) #1 n++;
    end
    while (phases[ph] === 1'b1 && len < 20000) begin
      @(posedge clk) #1 len++;
    end
    if (n >= 20000 || len >= 20000) begin
      bad_count++;
      results();
    end
  endtask
  task test_reset;
    rst = 1;
    repeat (4) @(posedge clk);
    #1 check("reset phases", 0, phases);
    check("reset reading", 0, reading);
    check("reset overrange", 0, overrange);
    rst = 0;
    repeat (2) @(posedge clk);
    #1 check("first phase", 1, phases);
    check("tick after reset", 0, countTick);
    $display("reset test done");
  endtask
  task test_cycle(input logic [11:0] n, input logic neg, input logic over);
    int li, ld, lz, la;
    crossAt = n;
    polarityIn = neg;
    phase_len(1, li);
    check("integrate clocks", INT_COUNTS * PRESCALE, li);
    check("deint after integrate", 1, deintEn);
    phase_len(2, ld);
    check("reading valid", 1, readingValid);
    check("count tick", 1, countTick);
    check("sign", neg, signNeg);
    check("reference select", neg, refNegSel);
    check("overrange", over, overrange);
    if (over)
      check("reading", FULL_SCALE, reading);
    else
      check("reading near crossing", 1, reading >= n && reading <= n + 2);
    phase_len(3, lz);
    check("valid pulse ended", 0, readingValid);
    check("discharge clocks", (over ? DISCH_HEAVY : DISCH_NORMAL) * PRESCALE, lz);
    phase_len(0, la);
    check("cycle clocks", CYCLE_COUNTS * PRESCALE, li + ld + lz + la);
    check("autozero floor", 1, la >= AZ_MIN * PRESCALE);
    $display("cycle test done");
  endtask
  initial begin
    test_reset();
    test_cycle(12'd0, 1'b1, 1'b0);
    test_cycle(12'd1999, 1'b0, 1'b0);
    test_cycle(12'hfff, 1'b1, 1'b1);
    phase_len(1, skipLen);
    check("integrate before mid reset", INT_COUNTS * PRESCALE, skipLen);
    test_reset();
    test_cycle(12'd500, 1'b0, 1'b0);
    results();
  end
endmodule // test_dual_slope_phase_sequencer
